// ### design/ncq_abort_pkg.sv
// Constants, types and helpers shared by the queued-command abort handler
package ncq_abort_pkg;

  // ==========================================================================
  // Command decode
  localparam logic [7:0] OPC_NCQ_NON_DATA = 8'h63;  // Queued non-data opcode
  localparam logic [3:0] SUB_ABORT        = 4'h0;   // Abort subcommand code
  localparam int         FEAT_SUB_LSB     = 0;      // Subcommand field
  localparam int         FEAT_SUB_MSB     = 3;
  localparam int         FEAT_TYPE_LSB    = 4;      // Abort type field
  localparam int         FEAT_TYPE_MSB    = 7;
  localparam int         CNT_TAG_LSB      = 3;      // Own queue tag
  localparam int         CNT_TAG_MSB      = 7;
  localparam int         CNT_PRIORITY_FIELD_LSB     = 14;     // Priority field
  localparam int         CNT_PRIORITY_FIELD_MSB     = 15;
  localparam int         LBA_TARGET_TAG_FIELD_LSB     = 3;      // Target tag
  localparam int         LBA_TARGET_TAG_FIELD_MSB     = 7;

  // ==========================================================================
  // Tags and abort types
  localparam int         TAG_W            = 5;      // Tag width
  localparam int         NUM_TAGS         = 32;     // Tag space
  localparam logic [3:0] TYPE_ALL         = 4'h0;   // Abort all
  localparam logic [3:0] TYPE_STREAM      = 4'h1;   // Abort streaming
  localparam logic [3:0] TYPE_NON_STREAM  = 4'h2;   // Abort non-streaming
  localparam logic [3:0] TYPE_SELECTED    = 4'h3;   // Abort selected tag
  localparam logic [15:0] SUPPORTED_RESET = 16'h000f;  // Types 0h..3h

  // ==========================================================================
  // Handler states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,  // Waiting for a command
    ST_EXEC = 2'b01   // Deciding and reporting
  } state_t;

  // One-hot bit for a tag, used for own tag and selected tag
  function automatic logic [NUM_TAGS-1:0] tag_bit(input logic [TAG_W-1:0] tag);
    logic [NUM_TAGS-1:0] mask;
    mask      = '0;
    mask[tag] = 1'b1;
    return mask;
  endfunction

endpackage

// ### design/abort_sel_if.sv
// Carrier between the abort handler and its tag selector
`timescale 1ns/100ps
interface abort_sel_if
  import ncq_abort_pkg::*;
();
  logic [3:0]          abort_type;   // Requested abort type
  logic [TAG_W-1:0]    own_tag;      // Tag of the abort command itself
  logic [TAG_W-1:0]    target_tag_field;         // Target tag
  logic [NUM_TAGS-1:0] outstanding;  // Queued commands in flight
  logic [NUM_TAGS-1:0] streaming;    // Which of those are streaming
  logic [NUM_TAGS-1:0] aborted;      // Tags chosen for abort

  modport req (output abort_type, own_tag, target_tag_field, outstanding, streaming,
               input aborted);
  modport sel (input abort_type, own_tag, target_tag_field, outstanding, streaming,
               output aborted);
endinterface

// ### design/abort_tag_select.sv
// Chooses which outstanding tags an abort request removes
`timescale 1ns/100ps
module abort_tag_select
  import ncq_abort_pkg::*;
(
  abort_sel_if.sel sel
);

  // ==========================================================================
  // Selection by abort type
  // Own tag is never in the set; it completes as the command itself
  always_comb begin
    logic [NUM_TAGS-1:0] pick;
    pick = '0;
    case (sel.abort_type)
      TYPE_ALL:        pick = sel.outstanding;
      TYPE_STREAM:     pick = sel.outstanding & sel.streaming;
      TYPE_NON_STREAM: pick = sel.outstanding & ~sel.streaming;
      TYPE_SELECTED:   pick = sel.outstanding & tag_bit(sel.target_tag_field);
      default:         pick = '0;
    endcase
    sel.aborted = pick & ~tag_bit(sel.own_tag);
  end

endmodule

// ### design/ncq_queue_abort_handler.sv
// Queued-command abort handler: decode, checks and completion report
`timescale 1ns/100ps
module ncq_queue_abort_handler
  import ncq_abort_pkg::*;
#(
  parameter logic [15:0] SUPPORTED_TYPES = SUPPORTED_RESET  // Bit n: type n supported
) (
  input  wire logic                mclk_i,         // 20 MHz clock
  input  wire logic                rstn_i,         // Synchronous reset, low
  input  wire logic                cmd_valid_i,    // Command presented, one cycle
  input  wire logic [7:0]          command_i,      // Opcode
  input  wire logic [15:0]         feature_i,      // Feature field
  input  wire logic [15:0]         count_i,        // Count field
  input  wire logic [47:0]         lba_i,          // LBA field
  input  wire logic                ncq_enable_i,   // Queuing enabled
  input  wire logic [TAG_W-1:0]    max_tag_i,      // Highest valid tag number
  input  wire logic [NUM_TAGS-1:0] outstanding_i,  // Outstanding queued tags
  input  wire logic [NUM_TAGS-1:0] streaming_i,    // Streaming flags per tag
  output logic                     busy_o,         // Command being handled
  output logic                     done_o,         // Completion pulse
  output logic                     err_o,          // Aborted-command error
  output logic                     sdb_valid_o,    // Send completion report
  output logic [NUM_TAGS-1:0]      sdb_act_o,      // Report tag bits
  output logic [NUM_TAGS-1:0]      aborted_o,      // Tags aborted, pulse
  output logic [1:0]               priority_field_o          // Priority of last accepted abort
);

  // ==========================================================================
  // State record
  typedef struct packed {
    state_t              state;      // Sequencer
    logic                busy;       // Busy flag
    logic [3:0]          abort_type; // Captured abort type
    logic [TAG_W-1:0]    own_tag;    // Captured own tag
    logic [TAG_W-1:0]    target_tag_field;       // Captured target tag
    logic [TAG_W-1:0]    max_tag;    // Depth limit at acceptance
    logic                ncq_on;     // Queuing state at acceptance
    logic [1:0]          priority_field;       // Captured priority
    logic                done;       // Completion pulse
    logic                err;        // Error result
    logic                sdb_valid;  // Report pulse
    logic [NUM_TAGS-1:0] sdb_act;    // Report bits
    logic [NUM_TAGS-1:0] aborted;    // Aborted tags
  } regs_t;

  regs_t st;       // Registered state
  regs_t next_st;  // Next state

  abort_sel_if sel_bus ();  // To the selector

  // ==========================================================================
  // Decode of the incoming command
  logic            accept;   // Abort subcommand taken this cycle
  logic [3:0]      in_type;  // Incoming abort type
  logic [TAG_W-1:0] in_tag;  // Incoming own tag
  logic [TAG_W-1:0] in_target_tag_field; // Incoming target tag

  assign in_type = feature_i[FEAT_TYPE_MSB:FEAT_TYPE_LSB];
  assign in_tag  = count_i[CNT_TAG_MSB:CNT_TAG_LSB];
  assign in_target_tag_field = lba_i[LBA_TARGET_TAG_FIELD_MSB:LBA_TARGET_TAG_FIELD_LSB];
  // Other opcodes and subcommands belong to other engines; ignored here
  assign accept  = cmd_valid_i && (st.state == ST_IDLE)
                && (command_i == OPC_NCQ_NON_DATA)
                && (feature_i[FEAT_SUB_MSB:FEAT_SUB_LSB] == SUB_ABORT);

  // ==========================================================================
  // Selector wiring: masks are sampled in the execute cycle
  assign sel_bus.abort_type  = st.abort_type;
  assign sel_bus.own_tag     = st.own_tag;
  assign sel_bus.target_tag_field        = st.target_tag_field;
  assign sel_bus.outstanding = outstanding_i;
  assign sel_bus.streaming   = streaming_i;

  abort_tag_select u_select (
    .sel (sel_bus.sel)
  );

  // ==========================================================================
  // Error checks on the captured command
  logic type_ok;   // Type supported
  logic target_tag_field_bad;  // Target tag unusable
  logic fail;      // Any error

  assign type_ok  = SUPPORTED_TYPES[st.abort_type];
  // Target tag only matters for the selected-tag type
  assign target_tag_field_bad = (st.abort_type == TYPE_SELECTED)
                 && ((st.target_tag_field == st.own_tag)
                  || (st.target_tag_field > st.max_tag));
  assign fail     = !st.ncq_on || !type_ok || target_tag_field_bad;

  // ==========================================================================
  // Next-state logic
  always_comb begin
    next_st           = st;
    next_st.done      = 1'b0;
    next_st.err       = 1'b0;  // Error flag lives only in the done cycle
    next_st.sdb_valid = 1'b0;
    next_st.aborted   = '0;
    case (st.state)
      ST_IDLE: begin
        if (accept) begin
          // Capture everything now so later input changes cannot skew checks
          next_st.state      = ST_EXEC;
          next_st.busy       = 1'b1;
          next_st.abort_type = in_type;
          next_st.own_tag    = in_tag;
          next_st.target_tag_field       = in_target_tag_field;
          next_st.max_tag    = max_tag_i;
          next_st.ncq_on     = ncq_enable_i;
          next_st.priority_field       = count_i[CNT_PRIORITY_FIELD_MSB:CNT_PRIORITY_FIELD_LSB];
        end
      end
      ST_EXEC: begin
        next_st.state = ST_IDLE;
        next_st.busy  = 1'b0;
        next_st.done  = 1'b1;
        next_st.err   = fail;
        if (!fail) begin
          // Success even when nothing was outstanding to abort
          next_st.sdb_valid = 1'b1;
          next_st.aborted   = sel_bus.aborted;
          next_st.sdb_act   = sel_bus.aborted | tag_bit(st.own_tag);
        end else begin
          next_st.sdb_act   = '0;  // Error path aborts nothing
        end
      end
      default: begin
        next_st.state = ST_IDLE;
        next_st.busy  = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // State register
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      st <= '{state: ST_IDLE, default: '0};
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state record
  assign busy_o      = st.busy;
  assign done_o      = st.done;
  assign err_o       = st.err;
  assign sdb_valid_o = st.sdb_valid;
  assign sdb_act_o   = st.sdb_act;
  assign aborted_o   = st.aborted;
  assign priority_field_o      = st.priority_field;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  // Abort subcommand taken on this edge
  sequence s_accept;
    accept;
  endsequence

  // Error reply two edges after acceptance
  sequence s_reply_err;
    ##2 (done_o && err_o);
  endsequence

  // Good reply, with its report, two edges after acceptance
  sequence s_reply_ok;
    ##2 (done_o && !err_o && sdb_valid_o);
  endsequence

  // Acceptance, one busy cycle, then the completion
  a_accept_done:    assert property (s_accept |-> ##1 busy_o ##1 done_o)
    else $error("accepted abort did not complete in two cycles");
  // A new command may be taken in the done cycle, so busy may rise right after it
  a_done_single:    assert property (done_o |-> !busy_o ##1 !done_o)
    else $error("completion pulse longer than one cycle");
  // Result pulses stay low between completions
  a_quiet_between:  assert property (
      !done_o |-> !err_o && !sdb_valid_o && (aborted_o == '0))
    else $error("result pulse outside the done cycle");

  // Each error cause on its own forces the aborted-command reply
  a_ncq_off_err:    assert property (accept && !ncq_enable_i |-> s_reply_err)
    else $error("abort with queuing off did not fail");
  a_self_target_tag_field_err:  assert property (
      accept && (in_type == TYPE_SELECTED) && (in_target_tag_field == in_tag) |-> s_reply_err)
    else $error("target tag equal to own tag did not fail");
  a_bad_target_tag_field_err:   assert property (
      accept && (in_type == TYPE_SELECTED) && (in_target_tag_field > max_tag_i) |-> s_reply_err)
    else $error("invalid target tag did not fail");
  a_unsup_type_err: assert property (
      accept && !SUPPORTED_TYPES[in_type] |-> s_reply_err)
    else $error("unsupported abort type did not fail");
  // A failed abort must leave the host queue alone
  a_err_no_abort:   assert property (
      done_o && err_o |-> (aborted_o == '0) && (sdb_act_o == '0))
    else $error("failed abort still removed tags");
  // Outside the selected-tag type a stray target tag must not cause a failure
  a_target_tag_field_ignored:   assert property (
      accept && ncq_enable_i && SUPPORTED_TYPES[in_type] && (in_type != TYPE_SELECTED)
      |-> s_reply_ok)
    else $error("target tag judged for a type that ignores it");

  // Report and its tag bits
  a_sdb_own_tag:    assert property (
      s_accept |-> ##2 ((sdb_valid_o == (done_o && !err_o))
                        && (!sdb_valid_o || sdb_act_o[$past(in_tag, 2)])))
    else $error("report missing or lacks own tag");
  a_abort_subset:   assert property (
      done_o |-> ((aborted_o & ~$past(outstanding_i)) == '0)
                 && ((aborted_o & ~sdb_act_o) == '0))
    else $error("aborted tags not outstanding or not reported");

  // Victim sets per abort type
  a_abort_all:      assert property (
      done_o && !err_o && ($past(st.abort_type) == TYPE_ALL)
      |-> (aborted_o | tag_bit($past(st.own_tag)))
          == ($past(outstanding_i) | tag_bit($past(st.own_tag))))
    else $error("abort-all missed an outstanding tag");
  a_abort_stream:   assert property (
      done_o && !err_o && ($past(st.abort_type) == TYPE_STREAM)
      |-> ((aborted_o & ~$past(streaming_i)) == '0))
    else $error("streaming abort touched a non-streaming tag");
  a_abort_nonstr:   assert property (
      done_o && !err_o && ($past(st.abort_type) == TYPE_NON_STREAM)
      |-> ((aborted_o & $past(streaming_i)) == '0))
    else $error("non-streaming abort touched a streaming tag");
  a_abort_sel:      assert property (
      done_o && !err_o && ($past(st.abort_type) == TYPE_SELECTED)
      |-> ((aborted_o & ~tag_bit($past(st.target_tag_field))) == '0))
    else $error("selected abort touched another tag");
  // The subset checks alone would pass an abort that removed nothing
  a_abort_sel_hit:  assert property (
      done_o && !err_o && ($past(st.abort_type) == TYPE_SELECTED)
      && $past(outstanding_i[st.target_tag_field]) |-> aborted_o[$past(st.target_tag_field)])
    else $error("selected outstanding tag was not aborted");

  // Priority is captured with the command that carries it
  a_priority_field_capture:   assert property (
      s_accept |=> (priority_field_o == $past(count_i[CNT_PRIORITY_FIELD_MSB:CNT_PRIORITY_FIELD_LSB])))
    else $error("priority not captured with the command");

endmodule

// ### tb/host_queue_model.sv
// Host-side queue model: outstanding and streaming tags, retired by completion reports
`timescale 1ns/100ps
module host_queue_model
  import ncq_abort_pkg::*;
(
  input  wire logic                mclk_i,         // Bench clock
  input  wire logic                rstn_i,         // Synchronous reset, low
  input  wire logic                load_i,         // Take a new queue picture
  input  wire logic [NUM_TAGS-1:0] load_out_i,     // New outstanding set
  input  wire logic [NUM_TAGS-1:0] load_str_i,     // New streaming set
  input  wire logic                sdb_valid_i,    // Completion report seen
  input  wire logic [NUM_TAGS-1:0] sdb_act_i,      // Tags that report completes
  output logic      [NUM_TAGS-1:0] outstanding_o,  // Tags in flight
  output logic      [NUM_TAGS-1:0] streaming_o     // Streaming flags
);
  // ==========================================================================
  // Queue state; a load wins over a retirement on the same edge
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      outstanding_o <= '0;
      streaming_o   <= '0;
    end else if (load_i) begin
      // Bench keeps the own tag out of this set in its random runs; the directed 0ff0h load still holds own tag 4
      outstanding_o <= load_out_i;
      streaming_o   <= load_str_i & load_out_i;
    end else if (sdb_valid_i) begin
      // Every tag in the report is finished on the host side
      outstanding_o <= outstanding_o & ~sdb_act_i;
      streaming_o   <= streaming_o & ~sdb_act_i;
    end
  end
endmodule

// ### tb/tb_ncq_queue_abort_handler.sv
// Self-checking bench for the queued-command abort handler
`timescale 1ns/100ps
module tb_ncq_queue_abort_handler import ncq_abort_pkg::*;;
  // ==========================================================================
  // Stimulus, observation and bookkeeping
  logic                mclk_i = 1'b0;
  logic                rstn = 1'b0;
  logic                cmd_valid = 1'b0;
  logic [7:0]          command = 8'h00;
  logic [15:0]         feature = 16'h0000;
  logic [15:0]         count = 16'h0000;
  logic [47:0]         lba = 48'h0;
  logic                ncq_enable = 1'b0;
  logic [TAG_W-1:0]    max_tag = 5'h00;
  logic                load = 1'b0;
  logic [NUM_TAGS-1:0] load_out = '0;
  logic [NUM_TAGS-1:0] load_str = '0;
  logic [NUM_TAGS-1:0] outstanding, streaming, sdb_act, aborted;
  logic                busy, done, err, sdb_valid;
  logic [1:0]          priority_field, last_priority_field = 2'h0;
  int                  fails = 0;
  int                  checked = 0;
  int                  cycles = 0;

  always #25 mclk_i = ~mclk_i;  // 20 MHz

  ncq_queue_abort_handler #(.SUPPORTED_TYPES(SUPPORTED_RESET)) dut (
    .mclk_i(mclk_i), .rstn_i(rstn), .cmd_valid_i(cmd_valid), .command_i(command),
    .feature_i(feature), .count_i(count), .lba_i(lba), .ncq_enable_i(ncq_enable),
    .max_tag_i(max_tag), .outstanding_i(outstanding), .streaming_i(streaming),
    .busy_o(busy), .done_o(done), .err_o(err), .sdb_valid_o(sdb_valid),
    .sdb_act_o(sdb_act), .aborted_o(aborted), .priority_field_o(priority_field));

  host_queue_model host (
    .mclk_i(mclk_i), .rstn_i(rstn), .load_i(load), .load_out_i(load_out),
    .load_str_i(load_str), .sdb_valid_i(sdb_valid), .sdb_act_i(sdb_act),
    .outstanding_o(outstanding), .streaming_o(streaming));

  // ==========================================================================
  // Verdict, comparison and expectation helpers
  task automatic close_out;
    if (fails == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Tags a supported type removes; own tag never counts as a victim
  function automatic logic [NUM_TAGS-1:0] exp_ab(input logic [3:0] ty,
      input logic [TAG_W-1:0] own, input logic [TAG_W-1:0] tt,
      input logic [NUM_TAGS-1:0] o, input logic [NUM_TAGS-1:0] s);
    logic [NUM_TAGS-1:0] m;
    m = o & ~(32'h1 << own);
    case (ty)
      TYPE_ALL:        return m;
      TYPE_STREAM:     return m & s;
      TYPE_NON_STREAM: return m & ~s;
      TYPE_SELECTED:   return m & (32'h1 << tt);
      default:         return '0;
    endcase
  endfunction

  // Load the host queue; called and left just after a rising edge
  task automatic load_q(input logic [NUM_TAGS-1:0] o, input logic [NUM_TAGS-1:0] s);
    load     = 1'b1;
    load_out = o;
    load_str = s;
    @(posedge mclk_i); #1;
    load     = 1'b0;
  endtask

  // One command, answer two edges later; queue read once it is settled
  task automatic run(input logic [7:0] op, input logic [15:0] ft, input logic [15:0] ct,
                     input logic [47:0] lb, input logic en, input logic [TAG_W-1:0] mt);
    logic                take, e_err;
    logic [3:0]          ty;
    logic [NUM_TAGS-1:0] e_ab, e_act;
    take = (op == OPC_NCQ_NON_DATA) && (ft[3:0] == SUB_ABORT);
    ty   = ft[7:4];
    // is host framing: device field bit 6 set, bit 4 clear; no port for it here
    {cmd_valid, command, feature, count, lba, ncq_enable, max_tag} =
        {1'b1, op, ft, ct, lb, en, mt};
    @(posedge mclk_i); #1;
    cmd_valid = 1'b0;
    // Target tag only judged for the selected-tag type
    e_err = !en || !SUPPORTED_RESET[ty] ||
            (ty == TYPE_SELECTED && (lb[7:3] == ct[7:3] || lb[7:3] > mt));
    e_ab  = e_err ? '0 : exp_ab(ty, ct[7:3], lb[7:3], outstanding, streaming);
    e_act = e_err ? '0 : (e_ab | (32'h1 << ct[7:3]));
    if (take) begin
      last_priority_field = ct[15:14];
    end
    check("busy", {31'h0, take}, {31'h0, busy});
    @(posedge mclk_i); #1;
    check("done", {31'h0, take}, {31'h0, done});
    if (take) begin
      check("err", {31'h0, e_err}, {31'h0, err});
      check("sdb_valid", {31'h0, !e_err}, {31'h0, sdb_valid});
      check("sdb_act", e_act, sdb_act);
      check("aborted", e_ab, aborted);
    end
    check("priority_field", {30'h0, last_priority_field}, {30'h0, priority_field});
  endtask

  // ==========================================================================
  // Hang guard
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      close_out();
    end
  end

  // ==========================================================================
  // Main sequence: corner cases first, then random traffic
  initial begin
    logic [TAG_W-1:0] mt, own, tt;
    logic [3:0]       ty;
    void'($urandom(69));
    repeat (20) @(posedge mclk_i);
    #1 rstn = 1'b1;
    // Every abort type plus an unsupported one, full queue, own tag 1
    for (int t = 0; t < 5; t++) begin
      load_q(32'hffff_fffd, 32'h5555_aaa8);
      run(8'h63, {8'h00, t[3:0], 4'h0}, 16'h4008, 48'h28, 1'b1, 5'h1f);
    end
    load_q(32'h0000_0ff0, 32'h0000_00f0);
    run(8'h63, 16'h0000, 16'h0008, 48'h0, 1'b0, 5'h1f);
    run(8'h63, 16'h0030, 16'h0020, 48'h20, 1'b1, 5'h1f);
    run(8'h63, 16'h0030, 16'h0020, 48'h48, 1'b1, 5'h07);
    run(8'h63, 16'h0030, 16'h0020, 48'h18, 1'b1, 5'h1f);
    run(8'h63, 16'h0020, 16'h0020, 48'h20, 1'b1, 5'h1f);
    run(8'h60, 16'h0000, 16'h0008, 48'h0, 1'b1, 5'h1f);
    run(8'h63, 16'h0001, 16'h0008, 48'h0, 1'b1, 5'h1f);
    // Random commands; the queue carries over between some of them
    for (int i = 0; i < 80; i++) begin
      mt  = 5'($urandom % 32);
      own = 5'($urandom % (mt + 1));
      ty  = 4'($urandom % 6);
      tt  = ($urandom % 8 == 0) ? 5'($urandom) : 5'($urandom % (mt + 1));
      if (outstanding[own] || $urandom % 2 == 0) begin
        load_q($urandom & ~(32'h1 << own), $urandom);
      end
      run(8'h63, {8'h00, ty, 4'h0}, {2'($urandom), 6'h00, own, 3'h0},
          {40'h0, tt, 3'h0}, ($urandom % 8) != 0, mt);
    end
    close_out();
  end
endmodule
